/* File: hdl/cycle_phase.sv */
// Divides the oscillator clock into the phases of one instruction cycle
`timescale 1ns/10ps
`include "instruction_format_timing_regs.svh"
module cycle_phase
#(
   parameter int PHASES = `IFT_PHASES
)
(
   input wire logic clk,
   input wire logic srst,
   output logic [1:0] phase,
   output logic last
);
   logic [1:0] next_phase;

   assign next_phase = (phase == 2'(PHASES - 1)) ? 2'h0 : 2'(phase + 2'h1);

   // Last is registered with the phase so it is high exactly in the final phase
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         phase <= 2'h0;
         last <= 1'b0;
      end
      else
      begin
         phase <= next_phase;
         last <= (next_phase == 2'(PHASES - 1));
      end
   end

   a_phase_wrap: assert property (@(posedge clk) disable iff (srst)
      (phase == 2'(PHASES - 1)) |=> (phase == 2'h0) && !last)
      else $error("Phase did not wrap at the end of the cycle");
endmodule // cycle_phase

/* File: hdl/instruction_format_timing.sv */
// Instruction word decode, read-modify-write sequencing and cycle timing
`timescale 1ns/10ps
`include "instruction_format_timing_regs.svh"
module instruction_format_timing
   import instruction_format_timing_pkg::*;
(
   input wire logic CLOCK,
   input wire logic SRST,
   input wire logic [15:0] INSTR_WORD,
   input wire logic [7:0] FILE_RDATA,
   input wire logic [7:0] ALU_RESULT,
   input wire logic [3:0] RAM_BANK,
   input wire logic [19:0] RETURN_ADDR,
   output logic [19:0] PROG_ADDR,
   output logic CYCLE_START,
   output logic NOP_CYCLE,
   output logic [5:0] ALU_OP,
   output logic [11:0] FILE_ADDR,
   output logic FILE_READ,
   output logic FILE_WRITE,
   output logic [7:0] FILE_WDATA,
   output logic ACCUM_WRITE,
   output logic [7:0] ACCUM_WDATA,
   output logic STACK_PUSH,
   output logic STACK_POP,
   output logic SHADOW_SAVE,
   output logic SHADOW_RESTORE,
   output logic TABLE_REQ,
   output logic TABLE_WRITE,
   output logic [1:0] TABLE_MODE,
   output logic POINTER_LOAD,
   output logic [1:0] POINTER_SEL,
   output logic [11:0] LITERAL
);
   logic [1:0] phase;
   logic phase_last;
   state_e state;
   state_e next_state;
   logic [19:0] next_pc;
   word_t ir;
   word_t ir2;
   logic [7:0] held;
   class_e cls;
   logic [3:0] top;
   logic [3:0] sub;
   logic live;
   logic first;
   logic second;
   logic is_dbl;
   logic is_ret;
   logic is_call;
   logic is_goto;
   logic is_lit;
   logic is_table;
   logic is_ptr;
   logic file_op;
   logic bit_mod;
   logic skip;
   logic jump;
   logic [19:0] rel;

   function automatic class_e classify(input logic [3:0] t);
      class_e c;
      c = CL_BYTE;
      case (t)
         `IFT_BIT_TOGGLE, `IFT_BIT_SET, `IFT_BIT_CLEAR,
         `IFT_BIT_SKIP_SET, `IFT_BIT_SKIP_CLR: c = CL_BIT;
         `IFT_MOVE2: c = CL_MOVE2;
         `IFT_BRANCH: c = CL_BRANCH;
         `IFT_CONTROL: c = CL_CONTROL;
         `IFT_TAIL: c = CL_TAIL;
         default: c = CL_BYTE;
      endcase
      return c;
   endfunction

   // Access RAM folds the low half onto bank zero and the high half onto the top bank
   function automatic logic [11:0] bank_addr(input logic a, input logic [7:0] f,
                                             input logic [3:0] bank);
      logic [3:0] hi;
      hi = (f < `IFT_ACCESS_SPLIT) ? `IFT_ACCESS_LOW_BANK : `IFT_ACCESS_HIGH_BANK;
      return a ? {bank, f} : {hi, f};
   endfunction

   function automatic logic [7:0] bit_modify(input logic [3:0] op, input logic [7:0] v,
                                             input logic [2:0] n);
      logic [7:0] m;
      m = 8'h01 << n;
      case (op)
         `IFT_BIT_SET: return v | m;
         `IFT_BIT_CLEAR: return v & ~m;
         default: return v ^ m;
      endcase
   endfunction

   cycle_phase #(
      .PHASES(`IFT_PHASES)
   ) u_phase (
      .clk(CLOCK),
      .srst(SRST),
      .phase(phase),
      .last(phase_last)
   );

   always_comb
   begin
      top = ir[15:12];
      sub = ir[11:8];
      cls = classify(top);
      live = (state != ST_FLUSH);
      first = (state == ST_EXEC);
      second = (state == ST_SECOND);
      is_ret = (cls == CL_CONTROL) && (sub == `IFT_SUB_MISC)
               && (ir[7:1] == `IFT_RETURN_CODE);
      is_call = (cls == CL_CONTROL) && (sub[3:1] == `IFT_SUB_CALL);
      is_goto = (cls == CL_CONTROL) && (sub == `IFT_SUB_GOTO);
      is_lit = (cls == CL_CONTROL) && (sub == `IFT_SUB_LIT);
      is_table = (cls == CL_CONTROL) && (sub == `IFT_SUB_TABLE);
      is_ptr = (cls == CL_CONTROL) && (sub == `IFT_SUB_PTR);
      is_dbl = (cls == CL_MOVE2) || is_call || is_goto || is_ptr;
      file_op = live && ((cls == CL_BYTE) || (cls == CL_BIT) || (cls == CL_MOVE2));
      bit_mod = (top == `IFT_BIT_TOGGLE) || (top == `IFT_BIT_SET) || (top == `IFT_BIT_CLEAR);
      skip = ((top == `IFT_BIT_SKIP_SET) && held[ir[11:9]])
             || ((top == `IFT_BIT_SKIP_CLR) && !held[ir[11:9]]);
      jump = (cls == CL_BRANCH) || is_ret;
      rel = {{9{ir[10]}}, ir[10:0]};
   end

   always_comb
   begin
      next_state = ST_EXEC;
      next_pc = 20'(PROG_ADDR + 20'h1);
      if (!live)
      begin
         next_pc = PROG_ADDR;
      end
      else if (first && is_dbl)
      begin
         next_state = ST_SECOND;
      end
      else if (first && skip)
      begin
         // A skipped double word leaves its tail to run as a no-operation
         next_state = ST_FLUSH;
         next_pc = 20'(PROG_ADDR + 20'h2);
      end
      else if (first && jump)
      begin
         next_state = ST_FLUSH;
         next_pc = is_ret ? RETURN_ADDR : 20'(PROG_ADDR + 20'h1 + rel);
      end
      else if (second && (is_goto || is_call))
      begin
         next_pc = {ir2[11:0], ir[7:0]};
      end
   end

   // Sequencer: program counter and state advance once per instruction cycle
   always_ff @(posedge CLOCK)
   begin
      if (SRST)
      begin
         state <= ST_EXEC;
         PROG_ADDR <= `IFT_RESET_VECTOR;
         CYCLE_START <= 1'b0;
         NOP_CYCLE <= 1'b0;
      end
      else
      begin
         CYCLE_START <= phase_last;
         if (phase_last)
         begin
            state <= next_state;
            PROG_ADDR <= next_pc;
            NOP_CYCLE <= (next_state == ST_FLUSH);
         end
      end
   end

   // Instruction words are sampled at the end of the fetch phase
   always_ff @(posedge CLOCK)
   begin
      if (SRST)
      begin
         ir <= `IFT_RESET_WORD;
         ir2 <= `IFT_RESET_WORD;
      end
      else if (phase == `IFT_FETCH_PHASE)
      begin
         if (first)
            ir <= INSTR_WORD;
         else if (second)
            ir2 <= INSTR_WORD;
      end
   end

   // Read step: every named file register is read, even pure destinations
   always_ff @(posedge CLOCK)
   begin
      if (SRST)
      begin
         FILE_READ <= 1'b0;
         FILE_ADDR <= 12'h000;
         ALU_OP <= 6'h00;
      end
      else
      begin
         FILE_READ <= (phase == `IFT_READ_PHASE) && file_op;
         if (phase == `IFT_READ_PHASE)
         begin
            ALU_OP <= (cls == CL_BYTE) ? ir[15:10] : 6'h00;
            if (cls == CL_MOVE2)
               FILE_ADDR <= second ? ir2[11:0] : ir[11:0];
            else
               FILE_ADDR <= bank_addr(ir[`IFT_A_BIT], ir[7:0], RAM_BANK);
         end
      end
   end

   // Held read value feeds skip tests and the destination of a two-word move
   always_ff @(posedge CLOCK)
   begin
      if (SRST)
         held <= 8'h00;
      else if (phase == `IFT_WRITE_PHASE && file_op)
         held <= FILE_RDATA;
   end

   // Write step: result goes where the instruction or its selector says
   always_ff @(posedge CLOCK)
   begin
      if (SRST)
      begin
         FILE_WRITE <= 1'b0;
         FILE_WDATA <= 8'h00;
         ACCUM_WRITE <= 1'b0;
         ACCUM_WDATA <= 8'h00;
      end
      else
      begin
         FILE_WRITE <= (phase == `IFT_WRITE_PHASE) && live
                       && (((cls == CL_BYTE) && ir[`IFT_D_BIT])
                       || ((cls == CL_BIT) && bit_mod)
                       || ((cls == CL_MOVE2) && second));
         ACCUM_WRITE <= (phase == `IFT_WRITE_PHASE) && live
                        && (((cls == CL_BYTE) && !ir[`IFT_D_BIT]) || is_lit);
         if (phase == `IFT_WRITE_PHASE)
         begin
            // Bit changes rewrite the sampled byte, so port pins land in the latches
            if (cls == CL_BIT)
               FILE_WDATA <= bit_modify(top, FILE_RDATA, ir[11:9]);
            else if (cls == CL_MOVE2)
               FILE_WDATA <= held;
            else
               FILE_WDATA <= ALU_RESULT;
            ACCUM_WDATA <= is_lit ? ir[7:0] : ALU_RESULT;
         end
      end
   end

   // Control strobes; the lone tail class falls through as a no-operation
   always_ff @(posedge CLOCK)
   begin
      if (SRST)
      begin
         STACK_PUSH <= 1'b0;
         STACK_POP <= 1'b0;
         SHADOW_SAVE <= 1'b0;
         SHADOW_RESTORE <= 1'b0;
         TABLE_REQ <= 1'b0;
         TABLE_WRITE <= 1'b0;
         TABLE_MODE <= 2'h0;
         POINTER_LOAD <= 1'b0;
         POINTER_SEL <= 2'h0;
         LITERAL <= 12'h000;
      end
      else
      begin
         STACK_PUSH <= (phase == `IFT_WRITE_PHASE) && second && is_call;
         STACK_POP <= (phase == `IFT_WRITE_PHASE) && first && is_ret;
         SHADOW_SAVE <= (phase == `IFT_WRITE_PHASE) && second && is_call
                        && ir[`IFT_CALL_S_BIT];
         SHADOW_RESTORE <= (phase == `IFT_WRITE_PHASE) && first && is_ret
                           && ir[`IFT_RET_S_BIT];
         TABLE_REQ <= (phase == `IFT_WRITE_PHASE) && first && is_table;
         POINTER_LOAD <= (phase == `IFT_WRITE_PHASE) && second && is_ptr;
         if (phase == `IFT_WRITE_PHASE && first && is_table)
         begin
            TABLE_WRITE <= ir[`IFT_TBL_WR_BIT];
            TABLE_MODE <= ir[1:0];
         end
         if (phase == `IFT_WRITE_PHASE && second && is_ptr)
         begin
            POINTER_SEL <= ir[5:4];
            LITERAL <= {ir[3:0], ir2[7:0]};
         end
      end
   end

   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (SRST);

   a_cycle_four: assert property (CYCLE_START |=> !CYCLE_START [*3] ##1 CYCLE_START)
      else $error("Instruction cycle is not four clocks");
   a_read_first: assert property (FILE_WRITE |-> $past(FILE_READ) && $stable(FILE_ADDR))
      else $error("File write without a read of the same register");
   a_dest_excl: assert property (!(FILE_WRITE && ACCUM_WRITE))
      else $error("Result written to both destinations");
   a_accum_dest: assert property ((phase == 2'h2 && live && cls == CL_BYTE && !ir[9])
      |=> ACCUM_WRITE && !FILE_WRITE && ACCUM_WDATA == $past(ALU_RESULT))
      else $error("Destination zero did not reach the accumulator");
   a_flush_quiet: assert property (NOP_CYCLE |-> !FILE_READ && !FILE_WRITE && !ACCUM_WRITE)
      else $error("Added cycle was not a no-operation");
   a_skip_two: assert property ((phase_last && first && skip)
      |=> NOP_CYCLE && PROG_ADDR == 20'($past(PROG_ADDR) + 20'h2))
      else $error("Taken test did not add a no-operation cycle");
   a_single_step: assert property ((phase_last && first && cls == CL_BYTE)
      |=> state == ST_EXEC && !NOP_CYCLE && PROG_ADDR == 20'($past(PROG_ADDR) + 20'h1))
      else $error("Byte instruction took more than one cycle");
   a_double_two: assert property ((phase_last && first && is_dbl)
      |=> state == ST_SECOND ##4 state == ST_EXEC)
      else $error("Double word did not take two cycles");
   a_tail_nop: assert property ((phase == 2'h2 && first && cls == CL_TAIL)
      |=> !FILE_WRITE && !ACCUM_WRITE && !STACK_PUSH && !POINTER_LOAD && !TABLE_REQ)
      else $error("Lone second word had an effect");
   a_port_back: assert property ((phase == 2'h2 && first && top == 4'h8)
      |=> FILE_WRITE && FILE_WDATA == ($past(FILE_RDATA) | (8'h01 << $past(ir[11:9]))))
      else $error("Bit set did not write back the sampled byte");
   a_access_ram: assert property ((phase == 2'h1 && first && cls == CL_BYTE && !ir[8])
      |=> FILE_ADDR[11:8] == (FILE_ADDR[7] ? 4'hf : 4'h0))
      else $error("Access RAM mapped to the wrong bank");
   a_shadow_call: assert property (SHADOW_SAVE |-> STACK_PUSH)
      else $error("Shadow save outside a call");

   c_skip: cover property (phase_last && first && skip);
   c_double: cover property (POINTER_LOAD);
   c_fast_ret: cover property (SHADOW_RESTORE);
   c_bit_write: cover property (FILE_WRITE && $past(cls == CL_BIT));
endmodule // instruction_format_timing

/* File: include/instruction_format_timing_pkg.sv */
// Types shared by the instruction decode and cycle timing front end
package instruction_format_timing_pkg;
   typedef logic [15:0] word_t;
   typedef enum logic [1:0] {
      ST_EXEC = 2'b00,
      ST_SECOND = 2'b01,
      ST_FLUSH = 2'b10
   } state_e;
   typedef enum logic [2:0] {
      CL_BYTE = 3'b000,
      CL_BIT = 3'b001,
      CL_MOVE2 = 3'b010,
      CL_BRANCH = 3'b011,
      CL_CONTROL = 3'b100,
      CL_TAIL = 3'b101
   } class_e;
endpackage

/* File: include/instruction_format_timing_regs.svh */
// Constants of the instruction decode and cycle timing front end
`ifndef INSTRUCTION_FORMAT_TIMING_REGS_SVH
`define INSTRUCTION_FORMAT_TIMING_REGS_SVH
// Oscillator periods per instruction cycle and the phase of each step
`define IFT_PHASES 4
`define IFT_FETCH_PHASE 2'h0
`define IFT_READ_PHASE 2'h1
`define IFT_WRITE_PHASE 2'h2
`define IFT_LAST_PHASE 2'h3
`define IFT_RESET_VECTOR 20'h00000
`define IFT_RESET_WORD 16'hf000
// Instruction classes by the top nibble of the first word
`define IFT_BYTE_TOP 4'h6
`define IFT_BIT_TOGGLE 4'h7
`define IFT_BIT_SET 4'h8
`define IFT_BIT_CLEAR 4'h9
`define IFT_BIT_SKIP_SET 4'ha
`define IFT_BIT_SKIP_CLR 4'hb
`define IFT_MOVE2 4'hc
`define IFT_BRANCH 4'hd
`define IFT_CONTROL 4'he
`define IFT_TAIL 4'hf
// Control sub-codes in bits 11:8
`define IFT_SUB_MISC 4'h0
`define IFT_SUB_TABLE 4'h1
`define IFT_SUB_LIT 4'h2
`define IFT_SUB_PTR 4'h3
`define IFT_SUB_GOTO 4'h4
`define IFT_SUB_CALL 3'h3
`define IFT_RETURN_CODE 7'h09
// Field positions
`define IFT_D_BIT 9
`define IFT_A_BIT 8
`define IFT_CALL_S_BIT 8
`define IFT_RET_S_BIT 0
`define IFT_TBL_WR_BIT 2
// Access RAM split
`define IFT_ACCESS_SPLIT 8'h80
`define IFT_ACCESS_LOW_BANK 4'h0
`define IFT_ACCESS_HIGH_BANK 4'hf
`endif

/* File: verification/core_side_model.sv */
// Program memory and file register model facing the decode front end
`timescale 1ns/10ps
module core_side_model
(
   input wire logic clk,
   input wire logic [19:0] prog_addr,
   input wire logic [11:0] file_addr,
   input wire logic file_read,
   input wire logic file_write,
   input wire logic [7:0] file_wdata,
   input wire logic [5:0] alu_op,
   output logic [15:0] instr_word,
   output logic [7:0] file_rdata,
   output logic [7:0] alu_result
);
   logic [15:0] prog [256];
   logic [7:0] ram [4096];
   logic [7:0] junk = 8'h3c;
   initial
   begin
      foreach (prog[i]) prog[i] = 16'hf000;
      foreach (ram[i]) ram[i] = 8'(i) ^ 8'ha5;
   end
   // Only 256 words: far jumps wrap onto the same cells the bench fills
   assign instr_word = prog[prog_addr[7:0]];
   // Outside a read strobe the data bus toggles so stale values never match
   assign file_rdata = file_read ? ram[file_addr] : junk;
   assign alu_result = file_rdata + {2'h0, alu_op};
   always @(posedge clk)
   begin
      junk <= ~junk;
      if (file_write)
         ram[file_addr] <= file_wdata;
   end
endmodule // core_side_model

/* File: verification/test_instruction_format_timing.sv */
// Self-checking bench for the instruction decode and cycle timing front end
`timescale 1ns/10ps
module test_instruction_format_timing
   import instruction_format_timing_pkg::*;
   ;
   typedef struct {
      logic [19:0] pa, rt;
      logic nop, rd, wr, aw, push, pop, sv, rs, treq, twr, cs, pl;
      logic [11:0] fa, lit;
      logic [7:0] data, wd, ad;
      logic [5:0] op;
      logic [3:0] bk;
      logic [1:0] tm, ps;
      int wt;
   } obs_s;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic [3:0] bank = 4'h0;
   logic [19:0] ret = 20'h0;
   logic [31:0] seed = 32'd16881;
   logic [19:0] pc;
   int miscompares = 0;
   int cmp_count = 0;
   wire [15:0] iw;
   wire [7:0] rdat, alu, wd, ad;
   wire [19:0] pa;
   wire cs, nop, fr, fw, aw, push, pop, sv, rs, treq, twr, pl;
   wire [5:0] op;
   wire [11:0] fa, lit;
   wire [1:0] tm, ps;
   always #10 clock = ~clock;
   instruction_format_timing dut (.CLOCK(clock), .SRST(srst), .INSTR_WORD(iw),
      .FILE_RDATA(rdat), .ALU_RESULT(alu), .RAM_BANK(bank), .RETURN_ADDR(ret),
      .PROG_ADDR(pa), .CYCLE_START(cs), .NOP_CYCLE(nop), .ALU_OP(op), .FILE_ADDR(fa),
      .FILE_READ(fr), .FILE_WRITE(fw), .FILE_WDATA(wd), .ACCUM_WRITE(aw),
      .ACCUM_WDATA(ad), .STACK_PUSH(push), .STACK_POP(pop), .SHADOW_SAVE(sv),
      .SHADOW_RESTORE(rs), .TABLE_REQ(treq), .TABLE_WRITE(twr), .TABLE_MODE(tm),
      .POINTER_LOAD(pl), .POINTER_SEL(ps), .LITERAL(lit));
   core_side_model mdl (.clk(clock), .prog_addr(pa), .file_addr(fa), .file_read(fr),
      .file_write(fw), .file_wdata(wd), .alu_op(op), .instr_word(iw),
      .file_rdata(rdat), .alu_result(alu));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [11:0] eaddr(logic [7:0] f, logic a, logic [3:0] b);
      if (a)
         return {b, f};
      return {(f < 8'h80) ? 4'h0 : 4'hf, f};
   endfunction
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // One instruction cycle: place word at the fetch address, sample the read and write steps
   task automatic step(input word_t w, output obs_s o);
      logic [31:0] r;
      o.wt = 0;
      while (cs !== 1'b1 && o.wt < 40)
      begin
         @(negedge clock);
         o.wt++;
      end
      r = rnd();
      bank = r[3:0];
      ret = r[27:8];
      o.bk = bank;
      o.rt = ret;
      o.pa = pa;
      o.nop = nop;
      if (nop !== 1'b1)
         mdl.prog[pa[7:0]] = w;
      repeat (2) @(negedge clock);
      o.rd = fr;
      o.fa = fa;
      o.data = rdat;
      o.op = op;
      o.cs = cs;
      @(negedge clock);
      {o.wr, o.wd, o.aw, o.ad, o.push, o.pop} = {fw, wd, aw, ad, push, pop};
      {o.sv, o.rs, o.treq, o.twr, o.tm} = {sv, rs, treq, twr, tm};
      {o.pl, o.ps, o.lit} = {pl, ps, lit};
      @(negedge clock);
   endtask
   initial
   begin
      #(20 * 20000);
      miscompares++;
      final_report();
   end
   initial
   begin
      obs_s o, p;
      word_t w, v;
      logic [31:0] r;
      logic [7:0] m, e;
      logic [3:0] c;
      logic t;
      repeat (10) @(negedge clock);
      srst = 1'b0;
      // The word at address zero runs once before the first cycle start is seen
      pc = 20'h1;
      for (int i = 0; i < 400; i++)
      begin
         r = rnd();
         c = r[3:0];
         w = {c, r[27:16]};
         v = {4'hf, r[15:4]};
         if (c == 4'he)
            case (r[9:8])
               2'h0: w = {8'he1, 5'h0, r[18:16]};
               2'h1: w = {8'he4, r[23:16]};
               2'h2: w = {7'h73, r[16], r[23:16]};
               default: w = {8'he0, 7'h09, r[16]};
            endcase
         // Literal and pointer loads borrow the table and jump slots when bit 10 is set
         if (c == 4'he && r[10] && !r[9])
            w = r[8] ? {8'he3, 2'h0, r[17:16], r[23:20]} : {8'he2, r[23:16]};
         step(w, o);
         chk("pc", o.pa, pc);
         chk("nop", o.nop, 1'b0);
         chk("mid", o.cs, 1'b0);
         if (i > 0)
            chk("period", o.wt, 0);
         if (c <= 4'h6)
         begin
            e = o.data + {2'h0, w[15:10]};
            chk("rd", o.rd, 1'b1);
            chk("addr", o.fa, eaddr(w[7:0], w[8], o.bk));
            chk("op", o.op, w[15:10]);
            chk("fwr", o.wr, w[9]);
            chk("awr", o.aw, !w[9]);
            chk("res", w[9] ? o.wd : o.ad, e);
            pc++;
         end
         else if (c <= 4'hb)
         begin
            m = 8'h01 << w[11:9];
            e = (c == 4'h7) ? o.data ^ m : (c == 4'h8) ? o.data | m : o.data & ~m;
            chk("rd", o.rd, 1'b1);
            chk("addr", o.fa, eaddr(w[7:0], w[8], o.bk));
            t = o.data[w[11:9]] == (c == 4'ha);
            if (c <= 4'h9)
               chk("bit", {o.wr, o.wd}, {1'b1, e});
            else
               chk("test", o.wr, 1'b0);
            pc = pc + ((c > 4'h9 && t) ? 20'h2 : 20'h1);
            if (c > 4'h9 && t)
            begin
               step(16'h0000, p);
               chk("skip", {p.nop, p.rd, p.wr}, 3'h4);
            end
         end
         else if (c == 4'hc)
         begin
            step(v, p);
            chk("src", {o.rd, o.wr, o.fa}, {2'h2, w[11:0]});
            chk("pc2", p.pa, pc + 20'h1);
            chk("dst", {p.nop, p.wr, p.fa, p.wd}, {2'h1, v[11:0], o.data});
            pc = pc + 20'h2;
         end
         else if (c == 4'hd)
         begin
            pc = pc + 20'h1 + {{9{w[10]}}, w[10:0]};
            step(16'h0000, p);
            chk("brnop", p.nop, 1'b1);
         end
         else if (c == 4'hf)
         begin
            chk("lone", {o.rd, o.wr, o.aw, o.push, o.pop, o.treq}, 0);
            pc++;
         end
         else if (r[10] && !r[9] && !r[8])
         begin
            chk("lit", {o.rd, o.aw, o.wr, o.ad}, {3'h2, w[7:0]});
            pc++;
         end
         else if (r[10] && !r[9])
         begin
            step(v, p);
            chk("pc2", {p.nop, p.pa}, {1'b0, pc + 20'h1});
            chk("ptr", {p.pl, p.ps, p.lit}, {1'b1, w[5:4], w[3:0], v[7:0]});
            pc = pc + 20'h2;
         end
         else if (r[9:8] == 2'h0)
         begin
            chk("table", {o.treq, o.twr, o.tm}, {1'b1, w[2:0]});
            pc++;
         end
         else if (r[9:8] == 2'h3)
         begin
            chk("ret", {o.pop, o.rs}, {1'b1, w[0]});
            pc = o.rt;
            step(16'h0000, p);
            chk("retnop", p.nop, 1'b1);
         end
         else
         begin
            step(v, p);
            chk("pc2", {p.nop, p.pa}, {1'b0, pc + 20'h1});
            chk("call", {p.push, p.sv}, {r[9], r[9] & w[8]});
            pc = {v[11:0], w[7:0]};
         end
      end
      srst = 1'b1;
      mdl.prog[0] = 16'hf000;
      repeat (2) @(negedge clock);
      chk("rst", {pa, fr, fw, aw, cs, nop}, 0);
      srst = 1'b0;
      pc = 20'h1;
      step(16'hf000, o);
      chk("pc0", o.pa, pc);
      final_report();
   end
endmodule // test_instruction_format_timing
